// *** rtl/sdl_defs.svh ***
`ifndef SDL_DEFS_SVH
`define SDL_DEFS_SVH

// Word layout of the conversion code.
`define SDL_WORD_W        16
`define SDL_MSB_W         4
`define SDL_LSB_W         12
`define SDL_SEG_N         15
`define SDL_BITCNT_W      5
`define SDL_CODE_RESET    16'h0000

// Core clock rate and conversion of a least time into whole cycles.
`define SDL_CLK_MHZ       200
`define SDL_CYC_CEIL(ns)  ((((ns) * `SDL_CLK_MHZ) + 999) / 1000)

// Serial link timing: clock limit in MHz, times in nanoseconds.
`define SDL_SCLK_MAX_MHZ  20
`define SDL_T_HALF_NS     25
`define SDL_T_SETUP_NS    30
`define SDL_T_HOLD_NS     30
`define SDL_T_CSHIGH_NS   60
`define SDL_T_LDDLY_NS    60
`define SDL_T_LDPULSE_NS  60

`define SDL_C_HALF        `SDL_CYC_CEIL(`SDL_T_HALF_NS)
`define SDL_C_SETUP       `SDL_CYC_CEIL(`SDL_T_SETUP_NS)
`define SDL_C_HOLD        `SDL_CYC_CEIL(`SDL_T_HOLD_NS)
`define SDL_C_CSHIGH      `SDL_CYC_CEIL(`SDL_T_CSHIGH_NS)
`define SDL_C_LDDLY       `SDL_CYC_CEIL(`SDL_T_LDDLY_NS)
`define SDL_C_LDPULSE     `SDL_CYC_CEIL(`SDL_T_LDPULSE_NS)

`endif

// *** rtl/sdl_pkg.sv ***
`include "sdl_defs.svh"

package sdl_pkg;

  typedef logic [`SDL_WORD_W-1:0] sdl_word_t;
  typedef logic [`SDL_SEG_N-1:0]  sdl_seg_t;
  typedef logic [`SDL_LSB_W-1:0]  sdl_ladder_t;

  typedef enum logic [2:0] {
    SDL_IDLE   = 3'b000,
    SDL_SETUP  = 3'b001,
    SDL_HIGH   = 3'b010,
    SDL_LOW    = 3'b011,
    SDL_HOLD   = 3'b100,
    SDL_GAP    = 3'b101,
    SDL_STROBE = 3'b110
  } sdl_host_st_t;

endpackage

// *** rtl/sdl_if.sv ***
`timescale 1ns/1ps

interface sdl_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic load_strobe_n;

  modport host (
    output sclk,
    output cs_n,
    output din,
    output load_strobe_n
  );

  modport dev (
    input sclk,
    input cs_n,
    input din,
    input load_strobe_n
  );
endinterface

// *** rtl/sdl_fifo.sv ***
`timescale 1ns/1ps

module sdl_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// *** rtl/sdl_host.sv ***
`timescale 1ns/1ps
`include "sdl_defs.svh"

module sdl_host #(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Word request
  input  wire sdl_pkg::sdl_word_t wr_word,
  input  wire logic              wr_defer,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  // Status
  output logic                   busy,
  // Serial link
  sdl_if.host                    link
);
  import sdl_pkg::*;

  localparam logic [7:0] C_HALF    = 8'(`SDL_C_HALF);
  localparam logic [7:0] C_SETUP   = 8'(`SDL_C_SETUP);
  localparam logic [7:0] C_HOLD    = 8'(`SDL_C_HOLD);
  localparam logic [7:0] C_CSHIGH  = 8'(`SDL_C_CSHIGH);
  localparam logic [7:0] C_LDDLY   = 8'(`SDL_C_LDDLY);
  localparam logic [7:0] C_LDPULSE = 8'(`SDL_C_LDPULSE);

  sdl_host_st_t             st_q;
  sdl_host_st_t             st_d;
  logic [7:0]               tmr_q;
  logic [7:0]               tmr_d;
  logic [`SDL_BITCNT_W-1:0] bits_q;
  sdl_word_t                sh_q;
  logic                     defer_q;
  logic                     defer_d;
  logic [`SDL_WORD_W:0]     f_data;
  logic                     f_valid;
  logic                     pop;
  logic                     shift;
  logic                     sclk_q;
  logic                     cs_n_q;
  logic                     din_q;
  logic                     ld_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // A stall of the serial engine backs the words up here, then into wr_ready.
  sdl_fifo #(
    .W     (`SDL_WORD_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   ({wr_defer, wr_word}),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (pop)
  );

  assign pop     = (st_q == SDL_IDLE);
  assign busy    = (st_q != SDL_IDLE);
  assign defer_d = (pop && f_valid) ? f_data[`SDL_WORD_W] : defer_q;
  assign shift   = (st_q == SDL_HIGH) && (tmr_q == '0) && (bits_q != 5'd1);

  ////////////////////////////////////////////////////////////////////////////
  // Each half period is at least 25 ns, so the link never passes 20 MHz.
  always_comb begin
    st_d  = st_q;
    tmr_d = (tmr_q == '0) ? '0 : tmr_q - 1'b1;
    case (st_q)
      SDL_IDLE: begin
        if (f_valid) begin
          st_d  = SDL_SETUP;
          tmr_d = C_SETUP - 1'b1;
        end
      end
      SDL_SETUP: begin
        if (tmr_q == '0) begin
          st_d  = SDL_HIGH;
          tmr_d = C_HALF - 1'b1;
        end
      end
      SDL_HIGH: begin
        if (tmr_q == '0) begin
          st_d  = (bits_q == 5'd1) ? SDL_HOLD : SDL_LOW;
          tmr_d = (bits_q == 5'd1) ? C_HOLD - 1'b1 : C_HALF - 1'b1;
        end
      end
      SDL_LOW: begin
        if (tmr_q == '0) begin
          st_d  = SDL_HIGH;
          tmr_d = C_HALF - 1'b1;
        end
      end
      SDL_HOLD: begin
        if (tmr_q == '0) begin
          st_d  = SDL_GAP;
          tmr_d = defer_q ? C_LDDLY - 1'b1 : C_CSHIGH - 1'b1;
        end
      end
      SDL_GAP: begin
        if (tmr_q == '0) begin
          st_d  = defer_q ? SDL_STROBE : SDL_IDLE;
          tmr_d = C_LDPULSE - 1'b1;
        end
      end
      SDL_STROBE: begin
        if (tmr_q == '0) begin
          st_d = SDL_IDLE;
        end
      end
      default: begin
        st_d = SDL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= SDL_IDLE;
      tmr_q   <= '0;
      defer_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      tmr_q   <= tmr_d;
      defer_q <= defer_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data changes on the falling clock edge, half a period before it is sampled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q   <= `SDL_CODE_RESET;
      bits_q <= '0;
      din_q  <= 1'b0;
    end else if (pop && f_valid) begin
      sh_q   <= f_data[`SDL_WORD_W-1:0];
      bits_q <= 5'(`SDL_WORD_W);
      din_q  <= f_data[`SDL_WORD_W-1];
    end else if (shift) begin
      sh_q   <= {sh_q[`SDL_WORD_W-2:0], 1'b0};
      bits_q <= bits_q - 1'b1;
      din_q  <= sh_q[`SDL_WORD_W-2];
    end
  end

  // Chip select and the clock burst exist only inside a frame.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      ld_n_q <= 1'b1;
    end else begin
      sclk_q <= (st_d == SDL_HIGH);
      cs_n_q <= !((st_d == SDL_SETUP) || (st_d == SDL_HIGH) ||
                  (st_d == SDL_LOW) || (st_d == SDL_HOLD));
      ld_n_q <= !((st_d == SDL_STROBE) || ((st_d != SDL_IDLE) && !defer_d));
    end
  end

  assign link.sclk          = sclk_q;
  assign link.cs_n          = cs_n_q;
  assign link.din           = din_q;
  assign link.load_strobe_n = ld_n_q;
endmodule

// *** rtl/sdl_dev.sv ***
// Functional notes
// - Every update is one sixteen-bit word.
// - Reset clears the conversion register to zero.
// - Top four bits drive fifteen thermometer switches.
// - Low twelve bits drive ladder switches directly.
// - Conversion code is unsigned straight binary.
// - Serial clock runs at most 20 MHz.
// - Shifting never disturbs the present output code.
// - Data sampled on rising serial clock edges.
// - Host holds select low for sixteen bits.
// - Words travel most significant bit first.
// - Shift only while chip select is low.
// - Select rise with strobe low loads output.
// - Select rise with strobe high only stores.
// - Strobe low later loads without serial clock.
// - Host selects only one converter at once.
// - Host runs the serial clock in bursts.
// - Strobe held low makes output follow input.
`timescale 1ns/1ps
`include "sdl_defs.svh"

module sdl_dev #(
  parameter bit LOAD_STROBE_PRESENT = 1'b1
) (
  // Clock and power-up reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Serial link
  sdl_if.dev              link,
  // Converter switch controls
  output sdl_pkg::sdl_word_t   dac_code,
  output sdl_pkg::sdl_seg_t    segment_switch_ctrl,
  output sdl_pkg::sdl_ladder_t ladder_switch_ctrl,
  // Status
  output logic                 word_pending
);
  import sdl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by the serial clock itself.

  sdl_word_t                sreg_q;
  logic [`SDL_BITCNT_W-1:0] cnt_q;
  logic                     new_frame_q;
  logic                     frame_idle;

  // The serial clock stops between frames, so frame start is marked by
  // chip select itself rather than by a clock edge that may never come.
  assign frame_idle = link.cs_n || !rst_b;

  always_ff @(posedge link.sclk or posedge frame_idle) begin
    if (frame_idle) begin
      new_frame_q <= 1'b1;
    end else begin
      new_frame_q <= 1'b0;
    end
  end

  // The serial input register is a plain shifter: after a long frame it
  // simply holds the last sixteen bits.
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      sreg_q <= `SDL_CODE_RESET;
    end else if (!link.cs_n) begin
      sreg_q <= {sreg_q[`SDL_WORD_W-2:0], link.din};
    end
  end

  // Bit count saturates at sixteen; it survives the end of the frame so the
  // core side can see whether the frame was complete.
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (!link.cs_n) begin
      if (new_frame_q) begin
        cnt_q <= 5'd1;
      end else if (cnt_q != 5'(`SDL_WORD_W)) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers for select and strobe.

  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic ld_meta_q;
  logic ld_sync_q;
  logic cs_rise;
  logic ld_low;
  logic frame_full;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      cs_meta_q <= link.cs_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
    end
  end

  // The strobe passes the same two stages as select, so a strobe already low
  // is seen low by the time the synchronised select rise arrives.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ld_meta_q <= 1'b1;
      ld_sync_q <= 1'b1;
    end else begin
      ld_meta_q <= link.load_strobe_n;
      ld_sync_q <= ld_meta_q;
    end
  end

  assign cs_rise    = cs_sync_q && !cs_prev_q;
  assign ld_low     = !LOAD_STROBE_PRESENT || !ld_sync_q;
  assign frame_full = (cnt_q == 5'(`SDL_WORD_W));

  ////////////////////////////////////////////////////////////////////////////
  // Word capture and transfer.
  //
  // The shifter and counter are read here only after a synchronised select
  // rise; the last serial edge precedes it by the select hold time, so both
  // are quiet and settled when sampled. A frame in progress is never read,
  // so a strobe during shifting cannot tear a word.

  sdl_word_t hold_q;
  logic      pend_q;
  sdl_word_t conv_q;
  logic      capture;
  logic      load_sreg;
  logic      load_hold;

  assign capture   = cs_rise && frame_full;
  // A deferred word waits in hold_q until the strobe is seen low.
  assign load_sreg = capture && ld_low;
  assign load_hold = !capture && pend_q && ld_low;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= `SDL_CODE_RESET;
    end else if (capture) begin
      hold_q <= sreg_q;
    end
  end

  // A fresh capture wins over the transfer that would clear the flag.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (capture) begin
      pend_q <= !ld_low;
    end else if (pend_q && ld_low) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_q <= `SDL_CODE_RESET;
    end else if (load_sreg) begin
      conv_q <= sreg_q;
    end else if (load_hold) begin
      conv_q <= hold_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch decode, registered so the switches change together.

  // Segment i is on when the upper nibble exceeds i.
  function automatic sdl_seg_t thermo(input logic [`SDL_MSB_W-1:0] v);
    thermo = '0;
    for (int i = 0; i < `SDL_SEG_N; i++) begin
      thermo[i] = (v > 4'(i));
    end
  endfunction

  sdl_seg_t    seg_q;
  sdl_ladder_t lad_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_q <= '0;
    end else begin
      seg_q <= thermo(conv_q[`SDL_WORD_W-1:`SDL_LSB_W]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lad_q <= '0;
    end else begin
      lad_q <= conv_q[`SDL_LSB_W-1:0];
    end
  end

  // The code is unsigned: zero is the bottom of the range, all ones the top.
  assign dac_code            = conv_q;
  assign segment_switch_ctrl = seg_q;
  assign ladder_switch_ctrl  = lad_q;
  assign word_pending        = pend_q;
endmodule

// *** testbench/sdl_sva.sv ***
`timescale 1ns/1ps

module sdl_sva
  import sdl_pkg::*;
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // Serial link
  input wire logic                 sclk,
  input wire logic                 cs_n,
  input wire logic                 din,
  input wire logic                 load_strobe_n,
  // Converter outputs
  input wire sdl_pkg::sdl_word_t   dac_code,
  input wire sdl_pkg::sdl_seg_t    segment_switch_ctrl,
  input wire sdl_pkg::sdl_ladder_t ladder_switch_ctrl,
  input wire logic                 word_pending
);
  import sdl_pkg::*;

  logic      sclk_q;
  logic      rise;
  logic [4:0] cnt_q;
  sdl_word_t sh_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////
  // The link clock comes from host flops, so sampling it on clk sees every edge.
  assign rise = sclk && !sclk_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 5'h00;
    else if (cs_n) cnt_q <= 5'h00;
    else if (rise && cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sh_q <= 16'h0000;
    else if (rise && !cs_n) sh_q <= {sh_q[14:0], din};
  end

  function automatic sdl_seg_t therm(input sdl_word_t w);
    for (int i = 0; i < 15; i++) therm[i] = (w[15:12] > i);
  endfunction

  ////////////////////////////////////////////////////////////////
  chk_reset_zero: assert property ($rose(rst_b) |-> dac_code == 16'h0000 && !word_pending)
    else $error("conversion code not zero after reset");
  chk_seg_thermo: assert property (segment_switch_ctrl == therm($past(dac_code)))
    else $error("segment controls do not match code");
  chk_ladder_copy: assert property (ladder_switch_ctrl == 12'($past(dac_code)))
    else $error("ladder controls do not match code");
  chk_code_frame: assert property (!cs_n [*8] |-> $stable(dac_code))
    else $error("output code moved during a frame");
  chk_rise_load: assert property ($rose(cs_n) && !load_strobe_n && cnt_q >= 5'h10 |-> ##5 dac_code == sh_q)
    else $error("select rise did not load the word");
  chk_defer_store: assert property ($rose(cs_n) && load_strobe_n && cnt_q >= 5'h10
    |=> $stable(dac_code) [*5] ##0 word_pending)
    else $error("deferred word changed the output");
  chk_strobe_load: assert property ($fell(load_strobe_n) && word_pending
    |-> ##4 dac_code == sh_q && !word_pending)
    else $error("strobe did not load the stored word");
  chk_frame_bits: assert property ($rose(cs_n) |-> cnt_q == 5'h10)
    else $error("frame length is not sixteen");
  chk_sclk_high: assert property ($rose(sclk) |=> sclk [*4])
    else $error("serial clock high phase too short");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
endmodule

// *** testbench/test_serial_dac_load_control.sv ***
`timescale 1ns/1ps

module test_serial_dac_load_control;
  import sdl_pkg::*;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  sdl_word_t   wr_word = 16'h0000;
  logic        wr_defer = 1'b0;
  logic        wr_valid = 1'b0;
  logic        wr_ready;
  logic        busy;
  logic        word_pending;
  logic        full_seen;
  sdl_word_t   dac_code;
  sdl_word_t   dac2;
  sdl_word_t   mon_q;
  sdl_word_t   w;
  sdl_seg_t    seg;
  sdl_ladder_t lad;
  int          err_count = 0;
  int          total_checks = 0;
  logic [31:0] rng = 32'h00008B23;
  sdl_word_t   corner [6] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h7FFF, 16'h0FFF, 16'hF000};

  sdl_if link ();
  sdl_if link2 ();

  always #2.5 clk = ~clk;

  sdl_host sdl_host_i (.clk(clk), .rst_b(rst_b), .wr_word(wr_word), .wr_defer(wr_defer), .wr_valid(wr_valid),
                       .wr_ready(wr_ready), .busy(busy), .link(link.host));
  sdl_dev sdl_dev_i (.clk(clk), .rst_b(rst_b), .link(link.dev), .dac_code(dac_code), .segment_switch_ctrl(seg),
                     .ladder_switch_ctrl(lad), .word_pending(word_pending));
  // Second device without a strobe pin, driven by the bench so that faults can be forced.
  sdl_dev #(.LOAD_STROBE_PRESENT(1'b0)) sdl_dev_i2 (.clk(clk), .rst_b(rst_b), .link(link2.dev), .dac_code(dac2),
                     .segment_switch_ctrl(), .ladder_switch_ctrl(), .word_pending());
  sdl_sva sdl_sva_i (.clk(clk), .rst_b(rst_b), .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din),
                     .load_strobe_n(link.load_strobe_n), .dac_code(dac_code), .segment_switch_ctrl(seg),
                     .ladder_switch_ctrl(lad), .word_pending(word_pending));

  always @(posedge link.sclk) if (!link.cs_n) mon_q <= {mon_q[14:0], link.din};

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction

  function automatic sdl_seg_t therm(input logic [3:0] n);
    for (int i = 0; i < 15; i++) therm[i] = (n > i);
  endfunction

  task automatic push(input sdl_word_t v, input logic d);
    int n;
    n = 0;
    @(negedge clk);
    wr_word = v;
    wr_defer = d;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1 && n < 4000) begin
      full_seen = 1'b1;
      n++;
      @(negedge clk);
    end
    @(negedge clk);
    wr_valid = 1'b0;
    check(n < 4000, 1);
  endtask

  task automatic settle();
    int n;
    int idle;
    n = 0;
    idle = 0;
    repeat (4) @(negedge clk);
    // Busy drops for one cycle between queued frames, so wait for a longer lull.
    while (idle < 3 && n < 4000) begin
      idle = (busy === 1'b0) ? idle + 1 : 0;
      n++;
      @(negedge clk);
    end
    repeat (10) @(negedge clk);
    check(n < 4000, 1);
  endtask

  task automatic expect_out(input sdl_word_t v);
    check(dac_code, v);
    check(seg, therm(v[15:12]));
    check(lad, v[11:0]);
    check(mon_q, v);
    check({link.sclk, link.cs_n, word_pending}, 3'b010);
  endtask

  // Released data line shows the inverse of its last bit, never a stale copy.
  task automatic frame2(input logic [31:0] bits, input int n, input logic sel);
    link2.cs_n = ~sel;
    #14;
    check(link.cs_n | link2.cs_n, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      link2.din = bits[i];
      #16 link2.sclk = 1'b1;
      #16 link2.sclk = 1'b0;
    end
    #20 link2.cs_n = 1'b1;
    link2.din = ~link2.din;
    repeat (12) @(negedge clk);
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    link2.sclk = 1'b0;
    link2.cs_n = 1'b1;
    link2.din = 1'b0;
    link2.load_strobe_n = 1'b1;
    full_seen = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check({dac_code, seg, word_pending}, 32'h0);
    check(32'(lad), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      w = (i < 6) ? corner[i] : rng[15:0];
      push(w, (i < 6) ? i[0] : rng[16]);
      settle();
      expect_out(w);
    end
    $display("test words done");
    full_seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      w = rng[15:0];
      push(w, 1'b0);
    end
    settle();
    check(full_seen, 1'b1);
    expect_out(w);
    $display("test buffer done");
    frame2(32'h0000A5C3, 16, 1'b1);
    check(dac2, 16'hA5C3);
    frame2(32'h000F1234, 20, 1'b1);
    check(dac2, 16'h1234);
    frame2(32'h000003FF, 10, 1'b1);
    check(dac2, 16'h1234);
    frame2(32'h00005555, 16, 1'b0);
    check(dac2, 16'h1234);
    rng = xs(rng);
    frame2({16'h0000, rng[15:0]}, 16, 1'b1);
    check(dac2, rng[15:0]);
    $display("test link faults done");
    test_done();
  end
endmodule
